/* File: verif/tafp_fan_pin_model.sv */
// Fan power stage: pull-up resistor on the open-drain fan drive pin.
// Assumes the block only ever pulls the pin low.
`default_nettype none
module tafp_fan_pin_model (
  // From the block
  input wire logic fanDriveOe_ff,
  input wire logic fanDriveOut_ff,
  // Level the power transistor gate sees
  output logic fanPin
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released pin floats up through the resistor
  assign fanPin = (fanDriveOe_ff && !fanDriveOut_ff) ? 1'b0 : 1'b1;
endmodule // tafp_fan_pin_model
`default_nettype wire

/* File: verif/tafp_top_assertions.sv */
// Port-level checker for the alarm block.
// Assumes it is bound onto tafp_top; nrst is the only async reset.
`default_nettype none
module tafp_top_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic softReset,
  // Inputs watched
  input wire tafp_pkg::tafp_config_s cfg,
  input wire tafp_pkg::tafp_limits_s localLimits,
  input wire tafp_pkg::tafp_limits_s remoteLimits,
  input wire logic [7:0] failsafeLimit,
  input wire logic resultValid,
  input wire logic [7:0] localTemp,
  input wire logic [7:0] remoteTemp,
  input wire logic statusFirstRead,
  // Outputs watched
  input wire logic [7:0] alarmStatusFirst_ff,
  input wire logic [7:0] alarmStatusSecond_ff,
  input wire logic overtempOutputN_ff,
  input wire logic clockThrottleOutputN_ff,
  input wire logic alertN_ff,
  input wire logic fanDriveOut_ff,
  input wire logic fanDriveOe_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////
  // A result the block accepts
  sequence s_take;
    resultValid && cfg.startEn && !softReset;
  endsequence
  // A critical flag stands with no soft reset pending
  sequence s_crit;
    (alarmStatusFirst_ff[7] || alarmStatusFirst_ff[6]) && !softReset;
  endsequence
  ////////////////////
  a_local_high_set: assert property (s_take ##0
    $signed(localTemp) >= $signed(localLimits.high) |=> alarmStatusFirst_ff[0])
    else $error("local high flag missing");
  a_remote_low_set: assert property (s_take ##0
    $signed(remoteTemp) <= $signed(remoteLimits.low) |=> alarmStatusFirst_ff[3])
    else $error("remote low flag missing");
  a_local_range: assert property (
    alarmStatusFirst_ff[0] || alarmStatusFirst_ff[1] |-> alarmStatusFirst_ff[4])
    else $error("local range flag missing");
  a_crit_pins: assert property (s_crit |=> !overtempOutputN_ff && !alertN_ff)
    else $error("critical pins not low");
  a_fault_latch: assert property (alarmStatusSecond_ff[1] && !softReset
    |=> alarmStatusSecond_ff[1] && !overtempOutputN_ff)
    else $error("diode fault not latched");
  a_throttle_low: assert property (s_take ##0
    $signed(localTemp) >= $signed(failsafeLimit) |=> !clockThrottleOutputN_ff)
    else $error("throttle not low");
  a_read_clears: assert property (statusFirstRead && !resultValid
    |=> alarmStatusFirst_ff == 8'h00 && alarmStatusSecond_ff[3:2] == 2'h0)
    else $error("status read did not clear");
  a_idle_hold: assert property (!cfg.startEn && !statusFirstRead && !softReset
    |=> $stable(alarmStatusFirst_ff)) else $error("detection while stopped");
  a_pin_release: assert property (!cfg.pwmEnable [*3]
    |-> !fanDriveOe_ff && !fanDriveOut_ff) else $error("fan pin not released");
endmodule // tafp_top_chk
bind tafp_top tafp_top_chk u_chk (.clk, .nrst, .softReset, .cfg, .localLimits,
  .remoteLimits, .failsafeLimit, .resultValid, .localTemp, .remoteTemp, .statusFirstRead,
  .alarmStatusFirst_ff, .alarmStatusSecond_ff, .overtempOutputN_ff,
  .clockThrottleOutputN_ff, .alertN_ff, .fanDriveOut_ff, .fanDriveOe_ff);
`default_nettype wire

/* File: verif/tafp_top_tb.sv */
// Self-checking bench for the alarm and fan PWM block.
// Assumes the pull-up model on the fan pin; range pin grounded until the 47 Hz check, then high to the end.
`default_nettype none
module tafp_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, nrst = 1'b0, softReset = 1'b0;
  tafp_pkg::tafp_config_s cfg = '0;
  tafp_pkg::tafp_limits_s lim = '{8'h32, 8'h0A, 8'h64};
  logic [7:0] duty = 8'h00, lt = 8'h00, rt = 8'h00, st1, st2, ldat, rdat;
  logic [2:0] fcode = 3'h0, fq;
  logic fwr = 1'b0, rv = 1'b0, fault = 1'b0, sRd1 = 1'b0, sRd2 = 1'b0, rsel = 1'b0;
  logic overtemp_output, thr, alrt, dout, doe, fanPin;
  int errors = 0, num_checks = 0, cyc = 0;
  always #10 clk = ~clk;
  // Same limits on both channels keeps expectations simple
  tafp_top u_dut (.clk(clk), .nrst(nrst), .softReset(softReset), .cfg(cfg),
    .localLimits(lim), .remoteLimits(lim), .passiveCoolingLimit(8'h14),
    .failsafeLimit(8'h50), .dutyCycleRegister(duty), .frequencyCode(fcode),
    .frequencyCodeWrite(fwr), .rangeSelectPin(rsel), .resultValid(rv), .localTemp(lt),
    .remoteTemp(rt), .diodeFault(fault), .statusFirstRead(sRd1), .statusSecondRead(sRd2),
    .alarmStatusFirst_ff(st1), .alarmStatusSecond_ff(st2), .localTempData_ff(ldat),
    .remoteTempData_ff(rdat), .frequencyCode_ff(fq), .overtempOutputN_ff(overtemp_output),
    .clockThrottleOutputN_ff(thr), .alertN_ff(alrt), .fanDriveOut_ff(dout),
    .fanDriveOe_ff(doe));
  tafp_fan_pin_model u_pin (.fanDriveOe_ff(doe), .fanDriveOut_ff(dout), .fanPin(fanPin));
  ////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One result pulse, then wait until alert has followed
  task automatic res(input logic [7:0] l, input logic [7:0] r, input logic f);
    @(posedge clk);
    rv <= 1'b1;
    lt <= l;
    rt <= r;
    fault <= f;
    @(posedge clk);
    rv <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic second);
    @(posedge clk);
    if (second) sRd2 <= 1'b1;
    else sRd1 <= 1'b1;
    @(posedge clk);
    sRd1 <= 1'b0;
    sRd2 <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  // Skip 4100 cycles, about two 25 kHz periods, then count low samples of the pin
  task automatic lows(output int k);
    repeat (4100) @(posedge clk);
    k = 0;
    repeat (2000) begin
      @(posedge clk);
      #1;
      k += (fanPin === 1'b0);
    end
  endtask
  task automatic waitv(input logic v);
    int i;
    for (i = 0; i < 5000 && fanPin !== v; i++) begin
      @(posedge clk);
      #1;
    end
  endtask
  ////////////////////
  task automatic t_reset();
    chk(st1 | st2, 8'h00);
    chk(rdat & ldat, 8'h80);
    chk({5'h00, fq}, 8'h03);
    chk({4'h0, overtemp_output, thr, alrt, doe}, 8'h0E);
    res(8'h7F, 8'h7F, 1'b0);
    chk(st1 | st2, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_limits();
    @(posedge clk);
    cfg.startEn <= 1'b1;
    res(8'h32, 8'h0A, 1'b0);
    res(8'h32, 8'h0A, 1'b0);
    chk(st1, 8'h39);
    chk({7'h00, alrt}, 8'h01);
    rd(1'b0);
    chk(st1, 8'h00);
    @(posedge clk);
    cfg.localRangeIrqEnable <= 1'b1;
    res(8'h32, 8'h1E, 1'b0);
    chk(st1, 8'h11);
    chk({7'h00, alrt}, 8'h00);
    $display("test limits done");
  endtask
  task automatic t_crit();
    res(8'h1E, 8'h64, 1'b0);
    chk(st1, 8'hB5);
    chk({6'h00, overtemp_output, thr}, 8'h00);
    chk(st2 & 8'h0C, 8'h08);
    rd(1'b0);
    res(8'h1E, 8'h64, 1'b0);
    chk(st2 & 8'h0C, 8'h00);
    res(8'h1E, 8'h4B, 1'b0);
    chk({7'h00, thr}, 8'h01);
    res(8'h1E, 8'h50, 1'b0);
    chk(st2 & 8'h0C, 8'h08);
    $display("test critical done");
  endtask
  task automatic t_pwm();
    int k;
    time t0;
    @(posedge clk);
    cfg.pwmEnable <= 1'b1;
    cfg.failsafeFullFanEnable <= 1'b1;
    lows(k);
    chk({7'h00, k == 2000}, 8'h01);
    @(posedge clk);
    cfg.failsafeFullFanEnable <= 1'b0;
    lows(k);
    chk({7'h00, k == 0}, 8'h01);
    @(posedge clk);
    duty <= 8'hFF;
    lows(k);
    chk({7'h00, k == 2000}, 8'h01);
    @(posedge clk);
    cfg.fanDrivePolarity <= 1'b1;
    lows(k);
    chk({7'h00, k == 0}, 8'h01);
    @(posedge clk);
    cfg.fanDrivePolarity <= 1'b0;
    cfg.pwmEnable <= 1'b0;
    lows(k);
    chk({7'h00, k == 0}, 8'h01);
    @(posedge clk);
    fcode <= 3'h5;
    fwr <= 1'b1;
    duty <= 8'h80;
    cfg.pwmEnable <= 1'b1;
    @(posedge clk);
    fwr <= 1'b0;
    waitv(1'b0);
    waitv(1'b1);
    waitv(1'b0);
    t0 = $time;
    waitv(1'b1);
    waitv(1'b0);
    chk({5'h00, fq}, 8'h05);
    // 40 kHz is 1250 cycles, within one 3.2 MHz tick
    k = int'(($time - t0) / 20);
    chk({7'h00, k > 1234 && k < 1266}, 8'h01);
    @(posedge clk);
    rsel <= 1'b1;
    // 47 Hz at half duty: the pin stays low through the whole window
    lows(k);
    chk({7'h00, k == 2000}, 8'h01);
    $display("test pwm done");
  endtask
  task automatic t_passive();
    rd(1'b0);
    res(8'h1E, 8'h14, 1'b0);
    chk({st2[0], alrt}, 8'h03);
    chk({7'h00, fanPin}, 8'h01);
    rd(1'b1);
    chk({7'h00, st2[0]}, 8'h00);
    @(posedge clk);
    cfg.passiveCoolingIrqEnable <= 1'b1;
    res(8'h1E, 8'h14, 1'b0);
    chk({st2[0], alrt}, 8'h02);
    rd(1'b1);
    @(posedge clk);
    cfg.maxOfBothMode <= 1'b1;
    res(8'h1E, 8'h14, 1'b0);
    chk({7'h00, st2[0]}, 8'h00);
    res(8'h14, 8'h14, 1'b0);
    chk({7'h00, st2[0]}, 8'h01);
    $display("test passive done");
  endtask
  task automatic t_diode();
    res(8'h1E, 8'h1E, 1'b1);
    chk({st2[1], overtemp_output}, 8'h02);
    chk(rdat, 8'h80);
    chk(ldat, 8'h1E);
    res(8'h1E, 8'h1E, 1'b0);
    rd(1'b0);
    rd(1'b1);
    chk({st2[1], overtemp_output}, 8'h02);
    @(posedge clk);
    softReset <= 1'b1;
    @(posedge clk);
    softReset <= 1'b0;
    @(posedge clk);
    #1;
    chk({st2[1], overtemp_output}, 8'h01);
    res(8'h1E, 8'h1E, 1'b1);
    chk({7'h00, st2[1]}, 8'h00);
    $display("test diode done");
  endtask
  ////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Guards against a hang in any wait loop
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      errors++;
      $display("unexpected at %0t: run too long", $time);
      test_done();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_limits();
    t_crit();
    t_pwm();
    t_passive();
    t_diode();
    test_done();
  end
endmodule // tafp_top_tb
`default_nettype wire

/* File: verilog/tafp_pkg.sv */
// Constants, field layouts and carrier types of the temperature alarm and fan PWM block.
// Assumes a 50 MHz system clock and that the caller feeds it temperature results and limits.
`default_nettype none

package tafp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map and field positions
  localparam logic [7:0] STATUS_FIRST_ADDR = 8'h02;
  localparam logic [7:0] STATUS_SECOND_ADDR = 8'h03;
  // Second status register field positions
  localparam int PASSIVE_BIT = 0;
  localparam int DIODE_FAULT_BIT = 1;
  localparam int LOCAL_FAILSAFE_BIT = 2;
  localparam int REMOTE_FAILSAFE_BIT = 3;
  // First status register field positions
  localparam int LOCAL_HIGH_BIT = 0;
  localparam int LOCAL_LOW_BIT = 1;
  localparam int REMOTE_HIGH_BIT = 2;
  localparam int REMOTE_LOW_BIT = 3;
  localparam int LOCAL_RANGE_BIT = 4;
  localparam int REMOTE_RANGE_BIT = 5;
  localparam int LOCAL_CRIT_BIT = 6;
  localparam int REMOTE_CRIT_BIT = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and codes
  localparam logic [7:0] TEMP_RESET_CODE = 8'h80;
  localparam logic [2:0] FREQ_CODE_RESET = 3'h3;
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam logic [7:0] FAILSAFE_HYST = 8'h05;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: system clock and PWM time base
  localparam int SYS_CLK_HZ = 50_000_000;
  localparam int TICK_HZ = 3_200_000;
  // Fractional accumulator: 50 MHz / 3.2 MHz = 125/8, step 8 modulo 125
  localparam logic [7:0] TICK_STEP = 8'(TICK_HZ / 400_000);
  localparam logic [7:0] TICK_MOD = 8'(SYS_CLK_HZ / 400_000);

  // Duty steps per period; the period itself is counted in 3.2 MHz ticks
  localparam int PWM_STEPS = 255;
  function automatic logic [18:0] period_ticks(input logic high_range, input logic [2:0] code);
    logic [31:0] hz;
    hz = 32'd30;
    if (high_range) begin
      case (code)
        3'h0: hz = 32'd1000;
        3'h1: hz = 32'd10000;
        3'h2: hz = 32'd20000;
        3'h3: hz = 32'd25000;
        3'h4: hz = 32'd30000;
        default: hz = 32'd40000;
      endcase
    end else begin
      case (code)
        3'h0: hz = 32'd10;
        3'h1: hz = 32'd15;
        3'h2: hz = 32'd23;
        3'h3: hz = 32'd30;
        3'h4: hz = 32'd38;
        3'h5: hz = 32'd47;
        3'h6: hz = 32'd62;
        default: hz = 32'd94;
      endcase
    end
    // Rounded to the nearest tick, so 30 kHz is approximate
    period_ticks = 19'((TICK_HZ + hz / 2) / hz);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Carrier types
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
    logic [7:0] crit;
  } tafp_limits_s;

  typedef struct packed {
    logic startEn;
    logic localRangeIrqEnable;
    logic remoteRangeIrqEnable;
    logic passiveCoolingIrqEnable;
    logic failsafeIrqEnable;
    logic diodeFaultIrqEnable;
    logic failsafeFullFanEnable;
    logic maxOfBothMode;
    logic pwmEnable;
    logic fanDrivePolarity;
  } tafp_config_s;

  typedef enum logic [1:0] {
    MON_IDLE,
    MON_FIRST,
    MON_RUN
  } tafp_mon_e;

endpackage

`default_nettype wire

/* File: verilog/tafp_pwm_gen.sv */
// PWM generator: 8-bit duty in 1/255 steps, period from a 3.2 MHz tick.
// Assumes tick is a one-cycle pulse at 3.2 MHz on average.
`default_nettype none

module tafp_pwm_gen #(
  parameter int PERIOD_W = 19
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Time base and settings
  input wire logic tick,
  input wire logic [PERIOD_W-1:0] periodTicks,
  input wire logic [7:0] duty,
  // Active-high on phase
  output logic pwmOn
);

  logic [PERIOD_W-1:0] tickCnt_ff; // Ticks into the current period
  logic [PERIOD_W+7:0] phase; // Position in period, scaled by 255
  logic [PERIOD_W+7:0] onLen; // On-time, duty scaled by period length

  ////////////////////////////////////////////////////////////////////////////
  // Period counter advanced by the 3.2 MHz tick; a shorter period wraps at once
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tickCnt_ff <= '0;
    end else if (tick) begin
      if (tickCnt_ff + 1'b1 >= periodTicks) begin
        tickCnt_ff <= '0;
      end else begin
        tickCnt_ff <= tickCnt_ff + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // On while count * 255 below duty * period: 0 never on, 255 always on
  // Cross-multiplying avoids a divider at the cost of two wide products
  assign phase = {8'h00, tickCnt_ff} * {{PERIOD_W{1'b0}}, 8'(tafp_pkg::PWM_STEPS)};
  assign onLen = {{PERIOD_W{1'b0}}, duty} * {8'h00, periodTicks};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwmOn <= 1'b0;
    end else begin
      pwmOn <= (phase < onLen);
    end
  end

endmodule // tafp_pwm_gen

`default_nettype wire

/* File: verilog/tafp_top.sv */
// Temperature alarm logic and open-drain fan PWM drive.
// Assumes results arrive with a one-cycle strobe; status reads come as one-cycle pulses.
`default_nettype none

module tafp_top (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic softReset,
  // Configuration and limits
  input wire tafp_pkg::tafp_config_s cfg,
  input wire tafp_pkg::tafp_limits_s localLimits,
  input wire tafp_pkg::tafp_limits_s remoteLimits,
  input wire logic [7:0] passiveCoolingLimit,
  input wire logic [7:0] failsafeLimit,
  input wire logic [7:0] dutyCycleRegister,
  input wire logic [2:0] frequencyCode,
  input wire logic frequencyCodeWrite,
  input wire logic rangeSelectPin,
  // Measurement results
  input wire logic resultValid,
  input wire logic [7:0] localTemp,
  input wire logic [7:0] remoteTemp,
  input wire logic diodeFault,
  // Status read strobes
  input wire logic statusFirstRead,
  input wire logic statusSecondRead,
  // Status and temperature data
  output logic [7:0] alarmStatusFirst_ff,
  output logic [7:0] alarmStatusSecond_ff,
  output logic [7:0] localTempData_ff,
  output logic [7:0] remoteTempData_ff,
  output logic [2:0] frequencyCode_ff,
  // Pins: overtemp, throttle and alert active low; fan drive as out and enable
  output logic overtempOutputN_ff,
  output logic clockThrottleOutputN_ff,
  output logic alertN_ff,
  output logic fanDriveOut_ff,
  output logic fanDriveOe_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  tafp_pkg::tafp_mon_e monState_ff; // Monitoring progress since reset
  logic cycleDone_ff; // Result just evaluated
  logic localArm_ff; // Local failsafe may set
  logic remoteArm_ff; // Remote failsafe may set
  logic faultLatch_ff; // Sticky diode fault
  logic [7:0] tickAcc_ff; // Fractional divider to 3.2 MHz
  logic tick_ff;
  logic [18:0] periodTicks; // Period length in 3.2 MHz ticks
  logic passiveState_ff; // Latest result calls for passive cooling
  logic pwmOn;
  logic [7:0] effDuty;
  logic evalNow;
  logic lHi, lLo, rHi, rLo, lCrit, rCrit, lFs, rFs, passive;
  logic lBelowHyst, rBelowHyst;
  logic [7:0] nxt_first;
  logic [7:0] nxt_second;

  // Signed compare helper: temperatures are two's complement
  function automatic logic ge_s(input logic [7:0] a, input logic [7:0] b);
    ge_s = $signed(a) >= $signed(b);
  endfunction

  // Failsafe re-arm threshold: limit minus hysteresis, widened to 9 bits so it cannot wrap
  function automatic logic below_hyst(input logic [7:0] t, input logic [7:0] lim);
    logic signed [8:0] thr;
    thr = $signed({lim[7], lim}) - $signed({1'b0, tafp_pkg::FAILSAFE_HYST});
    below_hyst = $signed({t[7], t}) <= thr;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Comparisons of the incoming results
  assign evalNow = resultValid && cfg.startEn && !softReset;
  assign lHi = ge_s(localTemp, localLimits.high);
  assign rHi = ge_s(remoteTemp, remoteLimits.high);
  assign lLo = ge_s(localLimits.low, localTemp);
  assign rLo = ge_s(remoteLimits.low, remoteTemp);
  assign lCrit = ge_s(localTemp, localLimits.crit);
  assign rCrit = ge_s(remoteTemp, remoteLimits.crit);
  assign lFs = ge_s(localTemp, failsafeLimit);
  assign rFs = ge_s(remoteTemp, failsafeLimit);
  assign lBelowHyst = below_hyst(localTemp, failsafeLimit);
  assign rBelowHyst = below_hyst(remoteTemp, failsafeLimit);
  // Remote-only control versus maximum of both
  assign passive = cfg.maxOfBothMode ?
    (ge_s(passiveCoolingLimit, localTemp) && ge_s(passiveCoolingLimit, remoteTemp)) :
    ge_s(passiveCoolingLimit, remoteTemp);

  ////////////////////////////////////////////////////////////////////////////
  // Monitoring progress: diode check and alerts wait for first cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      monState_ff <= tafp_pkg::MON_IDLE;
      cycleDone_ff <= 1'b0;
    end else begin
      cycleDone_ff <= evalNow;
      if (softReset) begin
        monState_ff <= tafp_pkg::MON_IDLE;
      end else begin
        case (monState_ff)
          tafp_pkg::MON_IDLE: if (evalNow) monState_ff <= tafp_pkg::MON_FIRST;
          tafp_pkg::MON_FIRST: if (evalNow) monState_ff <= tafp_pkg::MON_RUN;
          default: monState_ff <= tafp_pkg::MON_RUN;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Temperature data registers; fault forces most negative code
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      localTempData_ff <= tafp_pkg::TEMP_RESET_CODE;
      remoteTempData_ff <= tafp_pkg::TEMP_RESET_CODE;
    end else if (softReset) begin
      localTempData_ff <= tafp_pkg::TEMP_RESET_CODE;
      remoteTempData_ff <= tafp_pkg::TEMP_RESET_CODE;
    end else if (evalNow) begin
      localTempData_ff <= localTemp;
      // A faulty diode result is not trusted, report the floor code
      remoteTempData_ff <= (diodeFault && monState_ff != tafp_pkg::MON_IDLE) ?
        tafp_pkg::TEMP_RESET_CODE : remoteTemp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // First status register: sticky until read, set wins over read clear
  always_comb begin
    nxt_first = statusFirstRead ? 8'h00 : alarmStatusFirst_ff;
    if (evalNow) begin
      nxt_first[tafp_pkg::LOCAL_HIGH_BIT] = nxt_first[tafp_pkg::LOCAL_HIGH_BIT] | lHi;
      nxt_first[tafp_pkg::LOCAL_LOW_BIT] = nxt_first[tafp_pkg::LOCAL_LOW_BIT] | lLo;
      nxt_first[tafp_pkg::REMOTE_HIGH_BIT] = nxt_first[tafp_pkg::REMOTE_HIGH_BIT] | rHi;
      nxt_first[tafp_pkg::REMOTE_LOW_BIT] = nxt_first[tafp_pkg::REMOTE_LOW_BIT] | rLo;
      nxt_first[tafp_pkg::LOCAL_RANGE_BIT] =
        nxt_first[tafp_pkg::LOCAL_RANGE_BIT] | lHi | lLo;
      nxt_first[tafp_pkg::REMOTE_RANGE_BIT] =
        nxt_first[tafp_pkg::REMOTE_RANGE_BIT] | rHi | rLo;
      nxt_first[tafp_pkg::LOCAL_CRIT_BIT] = nxt_first[tafp_pkg::LOCAL_CRIT_BIT] | lCrit;
      nxt_first[tafp_pkg::REMOTE_CRIT_BIT] = nxt_first[tafp_pkg::REMOTE_CRIT_BIT] | rCrit;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alarmStatusFirst_ff <= 8'h00;
    end else if (softReset) begin
      alarmStatusFirst_ff <= 8'h00;
    end else begin
      alarmStatusFirst_ff <= nxt_first;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Failsafe arming: a read disarms, falling to limit minus 5 or below re-arms
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      localArm_ff <= 1'b1;
      remoteArm_ff <= 1'b1;
    end else if (softReset) begin
      localArm_ff <= 1'b1;
      remoteArm_ff <= 1'b1;
    end else begin
      if (statusFirstRead && alarmStatusSecond_ff[tafp_pkg::LOCAL_FAILSAFE_BIT]) begin
        localArm_ff <= 1'b0;
      end else if (evalNow && lBelowHyst) begin
        localArm_ff <= 1'b1;
      end
      if (statusFirstRead && alarmStatusSecond_ff[tafp_pkg::REMOTE_FAILSAFE_BIT]) begin
        remoteArm_ff <= 1'b0;
      end else if (evalNow && rBelowHyst) begin
        remoteArm_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Diode fault latch: only after first cycle, held until reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      faultLatch_ff <= 1'b0;
    end else if (softReset) begin
      faultLatch_ff <= 1'b0;
    end else if (evalNow && diodeFault && monState_ff != tafp_pkg::MON_IDLE) begin
      faultLatch_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Second status register: passive flag read-clears, failsafe by first read
  always_comb begin
    nxt_second = alarmStatusSecond_ff;
    if (statusSecondRead) begin
      nxt_second[tafp_pkg::PASSIVE_BIT] = 1'b0;
    end
    if (statusFirstRead) begin
      nxt_second[tafp_pkg::LOCAL_FAILSAFE_BIT] = 1'b0;
      nxt_second[tafp_pkg::REMOTE_FAILSAFE_BIT] = 1'b0;
    end
    if (evalNow) begin
      nxt_second[tafp_pkg::PASSIVE_BIT] = nxt_second[tafp_pkg::PASSIVE_BIT] | passive;
      nxt_second[tafp_pkg::LOCAL_FAILSAFE_BIT] =
        nxt_second[tafp_pkg::LOCAL_FAILSAFE_BIT] | (lFs && localArm_ff);
      nxt_second[tafp_pkg::REMOTE_FAILSAFE_BIT] =
        nxt_second[tafp_pkg::REMOTE_FAILSAFE_BIT] | (rFs && remoteArm_ff);
    end
    nxt_second[tafp_pkg::DIODE_FAULT_BIT] = faultLatch_ff;
    nxt_second[7:4] = 4'h0;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alarmStatusSecond_ff <= 8'h00;
    end else if (softReset) begin
      alarmStatusSecond_ff <= 8'h00;
    end else begin
      alarmStatusSecond_ff <= nxt_second;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins: overtemp on critical or latched fault, throttle on failsafe level
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      overtempOutputN_ff <= 1'b1;
      clockThrottleOutputN_ff <= 1'b1;
    end else if (softReset) begin
      overtempOutputN_ff <= 1'b1;
      clockThrottleOutputN_ff <= 1'b1;
    end else begin
      // Fault keeps the pin low even after the condition clears
      overtempOutputN_ff <= !(faultLatch_ff ||
        alarmStatusFirst_ff[tafp_pkg::LOCAL_CRIT_BIT] ||
        alarmStatusFirst_ff[tafp_pkg::REMOTE_CRIT_BIT]);
      if (evalNow) begin
        clockThrottleOutputN_ff <= !(lFs || rFs);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alert: critical unmasked, others masked; quiet before first cycle done
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alertN_ff <= 1'b1;
    end else if (softReset || monState_ff == tafp_pkg::MON_IDLE) begin
      alertN_ff <= 1'b1;
    end else begin
      alertN_ff <= !(
        alarmStatusFirst_ff[tafp_pkg::LOCAL_CRIT_BIT] ||
        alarmStatusFirst_ff[tafp_pkg::REMOTE_CRIT_BIT] ||
        (cfg.localRangeIrqEnable && alarmStatusFirst_ff[tafp_pkg::LOCAL_RANGE_BIT]) ||
        (cfg.remoteRangeIrqEnable && alarmStatusFirst_ff[tafp_pkg::REMOTE_RANGE_BIT]) ||
        (cfg.passiveCoolingIrqEnable && alarmStatusSecond_ff[tafp_pkg::PASSIVE_BIT]) ||
        (cfg.failsafeIrqEnable && (alarmStatusSecond_ff[tafp_pkg::LOCAL_FAILSAFE_BIT] ||
          alarmStatusSecond_ff[tafp_pkg::REMOTE_FAILSAFE_BIT])) ||
        (cfg.diodeFaultIrqEnable && faultLatch_ff));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frequency code register, default code 3 in either range
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frequencyCode_ff <= tafp_pkg::FREQ_CODE_RESET;
    end else if (softReset) begin
      frequencyCode_ff <= tafp_pkg::FREQ_CODE_RESET;
    end else if (frequencyCodeWrite) begin
      frequencyCode_ff <= frequencyCode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 3.2 MHz tick: 8/125 accumulator keeps average rate exact
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tickAcc_ff <= 8'h00;
      tick_ff <= 1'b0;
    end else if (tickAcc_ff + tafp_pkg::TICK_STEP >= tafp_pkg::TICK_MOD) begin
      tickAcc_ff <= tickAcc_ff + tafp_pkg::TICK_STEP - tafp_pkg::TICK_MOD;
      tick_ff <= 1'b1;
    end else begin
      tickAcc_ff <= tickAcc_ff + tafp_pkg::TICK_STEP;
      tick_ff <= 1'b0;
    end
  end

  // Grounded range pin selects the high range; floating reads high level
  assign periodTicks = tafp_pkg::period_ticks(!rangeSelectPin, frequencyCode_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Live passive state; the sticky flag would keep a warm fan stopped until read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      passiveState_ff <= 1'b0;
    end else if (softReset) begin
      passiveState_ff <= 1'b0;
    end else if (evalNow) begin
      passiveState_ff <= passive;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Duty: failsafe forces full when enabled; passive cooling stops fan
  always_comb begin
    effDuty = dutyCycleRegister;
    if (passiveState_ff) begin
      effDuty = 8'h00;
    end
    if (cfg.failsafeFullFanEnable && (alarmStatusSecond_ff[tafp_pkg::LOCAL_FAILSAFE_BIT] ||
        alarmStatusSecond_ff[tafp_pkg::REMOTE_FAILSAFE_BIT])) begin
      effDuty = tafp_pkg::DUTY_FULL;
    end
  end

  tafp_pwm_gen #(
    .PERIOD_W(19)
  ) uPwm (
    .clk(clk),
    .nrst(nrst),
    .tick(tick_ff),
    .periodTicks(periodTicks),
    .duty(effDuty),
    .pwmOn(pwmOn)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain drive: polarity 0 pulls low while on; disabled means released
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fanDriveOut_ff <= 1'b0;
      fanDriveOe_ff <= 1'b0;
    end else begin
      fanDriveOut_ff <= 1'b0;
      // Only low is ever driven; high comes from the external pull-up
      fanDriveOe_ff <= cfg.pwmEnable &&
        (cfg.fanDrivePolarity ? !pwmOn : pwmOn);
    end
  end

endmodule // tafp_top

`default_nettype wire
